// *** testbench/swpp_dev_model.sv ***
`timescale 1ns/1ps
module swpp_dev_model
    import swpp_pkg::*;
(
    // clock
    input wire logic clk_i,
    // setup
    input wire logic present_i,
    input wire logic [7:0] timer_end_count_i,
    // open-drain line
    input wire logic line_i,
    output logic dev_oe_o
);
    // never set: only skip selection is modelled
    logic resume_flag = 1'b0;
    logic [7:0] rom_b, cmd_b, dummy;
    logic [15:0] crc;
    logic rst;

    function automatic logic [15:0] calc_crc(input logic [15:0] data);
        logic [15:0] c;
        c = CRC16_SEED;
        for (int i = 0; i < 16; i++) begin
            c = (c[0] ^ data[i]) ? ((c >> 1) ^ CRC16_POLY) : (c >> 1);
        end
        return c;
    endfunction : calc_crc

    task automatic slot(input logic drive0, output logic rx, output logic is_rst);
        int n;
        n = 0;
        // own presence pull may still hold the line; wait for release first
        while (line_i === 1'b0) @(posedge clk_i);
        while (line_i !== 1'b0) @(posedge clk_i);
        dev_oe_o <= drive0;
        while (n < 1000 || line_i === 1'b0) begin
            @(posedge clk_i);
            n++;
            if (n == 750) dev_oe_o <= 1'b0;
            if (n == 1000) rx = line_i; // overdrive timing only
        end
        is_rst = n > IDLE_LOW_MAX_CYC;
    endtask : slot

    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic r);
        for (int i = 0; i < 8; i++) begin
            slot(!tx[i], rx[i], r);
        end
    endtask : xfer

    initial begin
        dev_oe_o = 1'b0;
        forever begin
            slot(1'b0, dummy[0], rst);
            if (rst) begin
                repeat (400) @(posedge clk_i);
                dev_oe_o <= present_i;
                repeat (2000) @(posedge clk_i);
                dev_oe_o <= 1'b0;
                if (present_i) begin
                    xfer(8'hFF, rom_b, rst);
                    // match, read and search need an id; unselected device waits for reset
                    if (rom_b == ROM_SKIP || rom_b == ROM_OD_SKIP ||
                        (rom_b == ROM_RESUME && resume_flag)) begin
                        xfer(8'hFF, cmd_b, rst);
                        if (cmd_b == CMD_READ_TIMEOUT) begin
                            crc = ~calc_crc({timer_end_count_i, cmd_b});
                            xfer(timer_end_count_i, dummy, rst);
                            xfer(crc[7:0], dummy, rst);
                            xfer(crc[15:8], dummy, rst);
                        end
                    end
                end
            end
        end
    end
endmodule : swpp_dev_model

// *** testbench/swpp_host_chk.sv ***
`timescale 1ns/1ps
module swpp_host_chk
    import swpp_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // request
    input wire logic start_i,
    input wire swpp_req_t req_i,
    input wire logic busy_o,
    // answer
    input wire logic done_o,
    input wire swpp_rsp_t rsp_o,
    input wire logic [63:0] found_id_o,
    // line
    input wire logic line_i,
    input wire logic line_o,
    input wire logic line_oe_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    // high phase and period counts saturate so idle gaps never wrap into short ones; low count does not
    logic [15:0] lo_ff, nxt_lo, hi_ff, nxt_hi, per_ff, nxt_per;
    logic oe_ff, rst_ff, nxt_rst;
    always_comb begin
        nxt_lo = line_oe_o ? lo_ff + 16'h0001 : 16'h0000;
        nxt_hi = line_oe_o ? 16'h0000 : hi_ff + {15'h0000, ~&hi_ff};
        nxt_per = (line_oe_o && !oe_ff) ? 16'h0001 : per_ff + {15'h0000, ~&per_ff};
        nxt_rst = (oe_ff && !line_oe_o) ? (lo_ff >= 16'(RESET_LOW_CYC)) : rst_ff;
    end
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            lo_ff <= 16'h0000;
            hi_ff <= 16'hFFFF;
            per_ff <= 16'hFFFF;
            oe_ff <= 1'b0;
            rst_ff <= 1'b0;
        end else begin
            lo_ff <= nxt_lo;
            hi_ff <= nxt_hi;
            per_ff <= nxt_per;
            oe_ff <= line_oe_o;
            rst_ff <= nxt_rst;
        end
    end

    a_line_open_drain: assert property (line_o == 1'b0)
        else $error("line data output not zero");
    a_start_busy: assert property (start_i && !busy_o |=> busy_o)
        else $error("start not taken");
    a_start_reset: assert property (start_i && !busy_o |-> ##[1:4] line_oe_o [*8])
        else $error("transaction not opened by reset pulse");
    a_low_widths: assert property ($fell(line_oe_o) |-> lo_ff inside
        {16'(ONE_LOW_CYC), 16'(READ_LOW_CYC), 16'(ZERO_LOW_CYC), 16'(RESET_LOW_CYC)})
        else $error("low phase of wrong length");
    a_slot_period: assert property ($rose(line_oe_o) |-> per_ff >= 16'(SLOT_CYC))
        else $error("slot started too early");
    a_reset_high: assert property ($rose(line_oe_o) && rst_ff |-> hi_ff >= 16'(RESET_HIGH_CYC))
        else $error("reset high time too short");
    a_idle_released: assert property (!busy_o |-> !line_oe_o)
        else $error("line pulled while idle");
    a_done_pulse: assert property (done_o |-> !line_oe_o ##1 !done_o)
        else $error("done not a released single pulse");
    a_no_presence: assert property (done_o && !rsp_o.presence |-> !rsp_o.crc_ok)
        else $error("crc good without presence");
endmodule : swpp_host_chk

bind swpp_host swpp_host_chk u_chk (.clk_i(clk_i), .reset_n_i(reset_n_i), .start_i(start_i),
    .req_i(req_i), .busy_o(busy_o), .done_o(done_o), .rsp_o(rsp_o), .found_id_o(found_id_o),
    .line_i(line_i), .line_o(line_o), .line_oe_o(line_oe_o));

// *** testbench/tb.sv ***
`timescale 1ns/1ps
module tb;
    import swpp_pkg::*;
    // two transactions at fixed overdrive timing need about 175k cycles
    localparam int LIMIT = 200000;
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic start_i = 1'b0;
    logic present = 1'b0;
    logic [7:0] timer_end_count = 8'h00;
    swpp_req_t req_i = '0;
    logic busy_o, done_o, line_o, line_oe_o, line_i, dev_oe;
    logic [63:0] found_id_o;
    swpp_rsp_t rsp_o, exp_r, want_r;
    swpp_rsp_t exp_q[$];
    int bad_count = 0;
    int compares = 0;
    int cycles = 0;
    int seed;

    always #2 clk_i = ~clk_i;
    // pullup returns the line high when nobody pulls
    assign line_i = ~(line_oe_o | dev_oe);

    swpp_host dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .start_i(start_i), .req_i(req_i),
        .busy_o(busy_o), .done_o(done_o), .rsp_o(rsp_o), .found_id_o(found_id_o),
        .line_i(line_i), .line_o(line_o), .line_oe_o(line_oe_o));
    swpp_dev_model u_dev (.clk_i(clk_i), .present_i(present), .timer_end_count_i(timer_end_count),
        .line_i(line_i), .dev_oe_o(dev_oe));

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask : check

    task automatic complete_run();
        $display("mismatches=%0d compares=%0d", bad_count, compares);
        if (bad_count == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : complete_run

    task automatic run_one(input logic pres, input swpp_rsp_t exp);
        exp_q.push_back(exp);
        @(posedge clk_i);
        #1 start_i = 1'b1;
        present = pres;
        req_i.rom_cmd = ROM_SKIP;
        @(posedge clk_i);
        #1 start_i = 1'b0;
        repeat (10) @(posedge clk_i);
        // a second request while busy must be ignored
        #1 start_i = 1'b1;
        req_i.rom_cmd = ROM_SEARCH;
        @(posedge clk_i);
        #1 start_i = 1'b0;
        while (busy_o !== 1'b0) @(posedge clk_i);
        repeat (5) @(posedge clk_i);
    endtask : run_one

    ////////////////////////////////////////////////////////////////
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            bad_count++;
            complete_run();
        end
        if (done_o === 1'b1) begin
            if (exp_q.size() == 0) begin
                check(64'h1, 64'h0);
            end else begin
                want_r = exp_q.pop_front();
                check(64'(rsp_o.presence), 64'(want_r.presence));
                check(64'(rsp_o.crc_ok), 64'(want_r.crc_ok));
                if (want_r.presence) begin
                    check(64'(rsp_o.timeout), 64'(want_r.timeout));
                    check(64'(rsp_o.crc), 64'(want_r.crc));
                end
            end
        end
    end

    initial begin
        repeat (4) @(posedge clk_i);
        #1 reset_n_i = 1'b1;
        seed = $urandom(76796);
        timer_end_count = 8'($urandom());
        req_i.rom_id = {$urandom(), $urandom()};
        exp_r = '0;
        run_one(1'b0, exp_r);
        exp_r = '{presence: 1'b1, crc_ok: 1'b1, timeout: timer_end_count,
            crc: ~u_dev.calc_crc({timer_end_count, CMD_READ_TIMEOUT})};
        run_one(1'b1, exp_r);
        check(64'(exp_q.size()), 64'h0);
        check(found_id_o, req_i.rom_id);
        complete_run();
    end
endmodule : tb

// *** verilog/swpp_crc16.sv ***
`timescale 1ns/1ps
// bitwise crc-16, reflected x16+x15+x2+1
module swpp_crc16
    import swpp_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // control
    input wire logic clear_i,
    input wire logic shift_i,
    input wire logic bit_i,
    // result
    output logic [15:0] crc_o
);

    logic [15:0] crc_ff, nxt_crc;

    always_comb begin
        nxt_crc = crc_ff;
        if (clear_i) begin
            nxt_crc = CRC16_SEED;
        end else if (shift_i) begin
            nxt_crc = {1'b0, crc_ff[15:1]} ^ ((crc_ff[0] ^ bit_i) ? CRC16_POLY : 16'h0000);
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            crc_ff <= 16'h0000;
        end else begin
            crc_ff <= nxt_crc;
        end
    end

    assign crc_o = crc_ff;

endmodule : swpp_crc16

// *** verilog/swpp_host.sv ***
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module swpp_host
    import swpp_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // request
    input wire logic start_i,
    input wire swpp_req_t req_i,
    output logic busy_o,
    // answer
    output logic done_o,
    output swpp_rsp_t rsp_o,
    output logic [63:0] found_id_o,
    // open-drain line
    input wire logic line_i,
    output logic line_o,
    output logic line_oe_o
);

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RESET,
        ST_ROM,
        ST_ID,
        ST_SEARCH,
        ST_CMD,
        ST_DATA,
        ST_FINISH
    } swpp_state_t;

    typedef enum logic [1:0] {
        TRI_TRUE,
        TRI_COMP,
        TRI_WRITE
    } swpp_tri_t;

    ////////////////////////////////////////////////////////////////////////////
    swpp_state_t state_ff, nxt_state;
    swpp_tri_t tri_ff, nxt_tri;
    swpp_req_t req_ff, nxt_req;
    logic [6:0] bit_cnt_ff, nxt_bit_cnt;
    logic [7:0] tx_ff, nxt_tx;
    logic [23:0] rx_ff, nxt_rx;
    logic [63:0] id_ff, nxt_id;
    logic true_bit_ff, nxt_true_bit;
    logic presence_ff, nxt_presence;
    logic busy_ff, nxt_busy;
    logic done_ff, nxt_done;
    logic slot_pending_ff, nxt_slot_pending;
    swpp_slot_t kind_ff, nxt_kind;
    swpp_rsp_t rsp_ff, nxt_rsp;
    logic oe_ff;

    logic slot_done, slot_bit, slot_oe;
    logic crc_clear, crc_shift, crc_bit;
    logic [15:0] crc_val;

    ////////////////////////////////////////////////////////////////////////////
    swpp_slot u_slot (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .start_i(slot_pending_ff),
        .kind_i(kind_ff),
        .line_i(line_i),
        .line_oe_o(slot_oe),
        .done_o(slot_done),
        .bit_o(slot_bit)
    );

    swpp_crc16 u_crc (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .clear_i(crc_clear),
        .shift_i(crc_shift),
        .bit_i(crc_bit),
        .crc_o(crc_val)
    );

    // crc covers command byte and received bytes, write or read alike
    assign crc_clear = (state_ff == ST_RESET);
    assign crc_shift = slot_done && (state_ff == ST_CMD || state_ff == ST_DATA);
    assign crc_bit = (state_ff == ST_CMD) ? tx_ff[0] : slot_bit;

    ////////////////////////////////////////////////////////////////////////////
    function automatic swpp_slot_t wr_kind(input logic b);
        wr_kind = b ? SLOT_WRITE1 : SLOT_WRITE0;
    endfunction : wr_kind

    always_comb begin
        nxt_state = state_ff;
        nxt_tri = tri_ff;
        nxt_req = req_ff;
        nxt_bit_cnt = bit_cnt_ff;
        nxt_tx = tx_ff;
        nxt_rx = rx_ff;
        nxt_id = id_ff;
        nxt_true_bit = true_bit_ff;
        nxt_presence = presence_ff;
        nxt_busy = busy_ff;
        nxt_done = 1'b0;
        nxt_slot_pending = 1'b0;
        nxt_kind = kind_ff;
        nxt_rsp = rsp_ff;
        unique case (state_ff)
            ST_IDLE: begin
                if (start_i) begin
                    nxt_req = req_i;
                    nxt_busy = 1'b1;
                    nxt_presence = 1'b0;
                    nxt_kind = SLOT_RESET;
                    nxt_slot_pending = 1'b1;
                    nxt_state = ST_RESET;
                end
            end
            ST_RESET: begin
                if (slot_done) begin
                    nxt_presence = ~slot_bit;
                    if (slot_bit) begin
                        nxt_state = ST_FINISH;
                    end else begin
                        // rom command next, lsb first
                        nxt_tx = req_ff.rom_cmd;
                        nxt_bit_cnt = '0;
                        nxt_kind = wr_kind(req_ff.rom_cmd[0]);
                        nxt_slot_pending = 1'b1;
                        nxt_state = ST_ROM;
                    end
                end
            end
            ST_ROM: begin
                if (slot_done) begin
                    nxt_tx = {1'b0, tx_ff[7:1]};
                    nxt_bit_cnt = bit_cnt_ff + 1'b1;
                    nxt_slot_pending = 1'b1;
                    if (bit_cnt_ff != 7'd7) begin
                        nxt_kind = wr_kind(tx_ff[1]);
                    end else begin
                        nxt_bit_cnt = '0;
                        nxt_tri = TRI_TRUE;
                        nxt_id = req_ff.rom_id;
                        unique case (req_ff.rom_cmd)
                            ROM_MATCH, ROM_OD_MATCH: begin
                                nxt_kind = wr_kind(req_ff.rom_id[0]);
                                nxt_state = ST_ID;
                            end
                            ROM_READ: begin
                                nxt_kind = SLOT_READ;
                                nxt_state = ST_ID;
                            end
                            ROM_SEARCH: begin
                                nxt_kind = SLOT_READ;
                                nxt_state = ST_SEARCH;
                            end
                            default: begin
                                // skip, resume, od skip: no identifier
                                nxt_tx = CMD_READ_TIMEOUT;
                                nxt_kind = wr_kind(CMD_READ_TIMEOUT[0]);
                                nxt_state = ST_CMD;
                            end
                        endcase
                    end
                end
            end
            ST_ID: begin
                if (slot_done) begin
                    nxt_id = {(req_ff.rom_cmd == ROM_READ) ? slot_bit : id_ff[0], id_ff[63:1]};
                    nxt_bit_cnt = bit_cnt_ff + 1'b1;
                    nxt_slot_pending = 1'b1;
                    if (bit_cnt_ff != 7'd63) begin
                        nxt_kind = (req_ff.rom_cmd == ROM_READ) ? SLOT_READ : wr_kind(id_ff[1]);
                    end else begin
                        nxt_bit_cnt = '0;
                        nxt_tx = CMD_READ_TIMEOUT;
                        nxt_kind = wr_kind(CMD_READ_TIMEOUT[0]);
                        nxt_state = ST_CMD;
                    end
                end
            end
            ST_SEARCH: begin
                if (slot_done) begin
                    nxt_slot_pending = 1'b1;
                    unique case (tri_ff)
                        TRI_TRUE: begin
                            nxt_true_bit = slot_bit;
                            nxt_kind = SLOT_READ;
                            nxt_tri = TRI_COMP;
                        end
                        TRI_COMP: begin
                            // on conflict take the requested branch bit
                            nxt_true_bit = (true_bit_ff == slot_bit) ? id_ff[0] : true_bit_ff;
                            nxt_kind = wr_kind(nxt_true_bit);
                            nxt_tri = TRI_WRITE;
                        end
                        default: begin
                            nxt_id = {true_bit_ff, id_ff[63:1]};
                            nxt_tri = TRI_TRUE;
                            nxt_bit_cnt = bit_cnt_ff + 1'b1;
                            nxt_kind = SLOT_READ;
                            if (bit_cnt_ff == 7'd63) begin
                                nxt_bit_cnt = '0;
                                nxt_tx = CMD_READ_TIMEOUT;
                                nxt_kind = wr_kind(CMD_READ_TIMEOUT[0]);
                                nxt_state = ST_CMD;
                            end
                        end
                    endcase
                end
            end
            ST_CMD: begin
                if (slot_done) begin
                    nxt_tx = {1'b0, tx_ff[7:1]};
                    nxt_bit_cnt = bit_cnt_ff + 1'b1;
                    nxt_slot_pending = 1'b1;
                    if (bit_cnt_ff != 7'd7) begin
                        nxt_kind = wr_kind(tx_ff[1]);
                    end else begin
                        nxt_bit_cnt = '0;
                        nxt_kind = SLOT_READ;
                        nxt_state = ST_DATA;
                    end
                end
            end
            ST_DATA: begin
                if (slot_done) begin
                    // byte then crc lsb byte then msb byte, all lsb first
                    nxt_rx = {slot_bit, rx_ff[23:1]};
                    nxt_bit_cnt = bit_cnt_ff + 1'b1;
                    if (bit_cnt_ff != 7'd23) begin
                        nxt_kind = SLOT_READ;
                        nxt_slot_pending = 1'b1;
                    end else begin
                        nxt_state = ST_FINISH;
                    end
                end
            end
            ST_FINISH: begin
                nxt_rsp.presence = presence_ff;
                nxt_rsp.timeout = rx_ff[7:0];
                nxt_rsp.crc = rx_ff[23:8];
                // residue over data plus inverted crc
                nxt_rsp.crc_ok = presence_ff && (crc_val == CRC16_GOOD);
                nxt_busy = 1'b0;
                nxt_done = 1'b1;
                nxt_state = ST_IDLE;
            end
            default: nxt_state = ST_IDLE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_ff <= ST_IDLE;
            tri_ff <= TRI_TRUE;
            req_ff <= '0;
            bit_cnt_ff <= '0;
            tx_ff <= 8'h00;
            rx_ff <= 24'h000000;
            id_ff <= 64'h0;
            true_bit_ff <= 1'b0;
            presence_ff <= 1'b0;
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
            slot_pending_ff <= 1'b0;
            kind_ff <= SLOT_WRITE1;
            rsp_ff <= '0;
            oe_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            tri_ff <= nxt_tri;
            req_ff <= nxt_req;
            bit_cnt_ff <= nxt_bit_cnt;
            tx_ff <= nxt_tx;
            rx_ff <= nxt_rx;
            id_ff <= nxt_id;
            true_bit_ff <= nxt_true_bit;
            presence_ff <= nxt_presence;
            busy_ff <= nxt_busy;
            done_ff <= nxt_done;
            slot_pending_ff <= nxt_slot_pending;
            kind_ff <= nxt_kind;
            rsp_ff <= nxt_rsp;
            oe_ff <= slot_oe;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // extra flop keeps outputs registered; delays both edges by one cycle, low widths unchanged
    assign line_oe_o = oe_ff;
    assign line_o = 1'b0; // open drain: only ever drives low
    assign busy_o = busy_ff;
    assign done_o = done_ff;
    assign rsp_o = rsp_ff;
    assign found_id_o = id_ff;

endmodule : swpp_host

// *** verilog/swpp_pkg.sv ***
package swpp_pkg;

    localparam int CLK_MHZ = 250;

    // line timing, overdrive speed, in nanoseconds
    localparam int RESET_LOW_NS = 80000;
    localparam int RESET_HIGH_NS = 48000;
    localparam int PRESENCE_SAMPLE_NS = 8000;
    localparam int ZERO_LOW_NS = 8000;
    localparam int ONE_LOW_NS = 1000;
    localparam int READ_LOW_NS = 1000;
    localparam int READ_SAMPLE_NS = 2000;
    localparam int SLOT_NS = 11000;
    localparam int IDLE_LOW_MAX_NS = 15500;

    // least times round up to whole cycles
    localparam int RESET_LOW_CYC = (RESET_LOW_NS * CLK_MHZ + 999) / 1000;
    localparam int RESET_HIGH_CYC = (RESET_HIGH_NS * CLK_MHZ + 999) / 1000;
    localparam int ZERO_LOW_CYC = (ZERO_LOW_NS * CLK_MHZ + 999) / 1000;
    localparam int READ_LOW_CYC = (READ_LOW_NS * CLK_MHZ + 999) / 1000;
    localparam int SLOT_CYC = (SLOT_NS * CLK_MHZ + 999) / 1000;
    // longest times round down
    localparam int PRESENCE_SAMPLE_CYC = (PRESENCE_SAMPLE_NS * CLK_MHZ) / 1000;
    localparam int ONE_LOW_CYC = (ONE_LOW_NS * CLK_MHZ) / 1000;
    localparam int READ_SAMPLE_CYC = (READ_SAMPLE_NS * CLK_MHZ) / 1000;
    localparam int IDLE_LOW_MAX_CYC = (IDLE_LOW_MAX_NS * CLK_MHZ) / 1000;

    localparam int TIMER_W = 15;

    // rom function commands
    localparam logic [7:0] ROM_SEARCH = 8'hF0;
    localparam logic [7:0] ROM_READ = 8'h33;
    localparam logic [7:0] ROM_MATCH = 8'h55;
    localparam logic [7:0] ROM_SKIP = 8'hCC;
    localparam logic [7:0] ROM_RESUME = 8'hA5;
    localparam logic [7:0] ROM_OD_SKIP = 8'h3C;
    localparam logic [7:0] ROM_OD_MATCH = 8'h69;
    // device function command
    localparam logic [7:0] CMD_READ_TIMEOUT = 8'h99;

    localparam logic [15:0] CRC16_POLY = 16'hA001;
    localparam logic [15:0] CRC16_SEED = 16'h0000;
    localparam logic [15:0] CRC16_GOOD = 16'hB001;

    typedef enum logic [1:0] {
        SLOT_RESET,
        SLOT_WRITE0,
        SLOT_WRITE1,
        SLOT_READ
    } swpp_slot_t;

    typedef struct packed {
        logic line_o;
        logic line_oe;
    } swpp_pin_t;

    typedef struct packed {
        logic [7:0] rom_cmd;
        logic [63:0] rom_id;
    } swpp_req_t;

    typedef struct packed {
        logic presence;
        logic crc_ok;
        logic [7:0] timeout;
        logic [15:0] crc;
    } swpp_rsp_t;

endpackage : swpp_pkg

// *** verilog/swpp_slot.sv ***
`timescale 1ns/1ps
// drives one reset or bit slot on the open-drain line and samples it
module swpp_slot
    import swpp_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // request
    input wire logic start_i,
    input wire swpp_slot_t kind_i,
    // line
    input wire logic line_i,
    output logic line_oe_o,
    // answer
    output logic done_o,
    output logic bit_o
);

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_LOW,
        ST_HIGH
    } swpp_sl_state_t;

    swpp_sl_state_t state_ff, nxt_state;
    swpp_slot_t kind_ff, nxt_kind;
    logic [TIMER_W-1:0] cnt_ff, nxt_cnt;
    logic [TIMER_W-1:0] low_len, total_len, smp_at;
    logic bit_ff, nxt_bit;
    logic done_ff, nxt_done;
    logic oe_ff, nxt_oe;

    always_comb begin
        unique case (kind_ff)
            SLOT_RESET: begin
                low_len = TIMER_W'(RESET_LOW_CYC);
                smp_at = TIMER_W'(RESET_LOW_CYC + PRESENCE_SAMPLE_CYC);
                total_len = TIMER_W'(RESET_LOW_CYC + RESET_HIGH_CYC);
            end
            SLOT_WRITE0: begin
                low_len = TIMER_W'(ZERO_LOW_CYC);
                smp_at = TIMER_W'(ZERO_LOW_CYC);
                total_len = TIMER_W'(SLOT_CYC);
            end
            SLOT_WRITE1: begin
                low_len = TIMER_W'(ONE_LOW_CYC);
                smp_at = TIMER_W'(ONE_LOW_CYC);
                total_len = TIMER_W'(SLOT_CYC);
            end
            SLOT_READ: begin
                low_len = TIMER_W'(READ_LOW_CYC);
                smp_at = TIMER_W'(READ_SAMPLE_CYC);
                total_len = TIMER_W'(SLOT_CYC);
            end
        endcase
    end

    always_comb begin
        nxt_state = state_ff;
        nxt_kind = kind_ff;
        nxt_cnt = cnt_ff;
        nxt_bit = bit_ff;
        nxt_done = 1'b0;
        nxt_oe = oe_ff;
        unique case (state_ff)
            ST_IDLE: begin
                // only falling edges come from here; idle leaves line released
                if (start_i) begin
                    nxt_kind = kind_i;
                    nxt_cnt = '0;
                    nxt_oe = 1'b1;
                    nxt_state = ST_LOW;
                end
            end
            ST_LOW: begin
                nxt_cnt = cnt_ff + 1'b1;
                if (cnt_ff == low_len - 1'b1) begin
                    nxt_oe = 1'b0;
                    nxt_state = ST_HIGH;
                end
            end
            ST_HIGH: begin
                nxt_cnt = cnt_ff + 1'b1;
                // presence is active low; read 0 is device pulldown
                if (cnt_ff == smp_at) begin
                    nxt_bit = line_i;
                end
                // full slot incl. recovery before next one
                if (cnt_ff == total_len - 1'b1) begin
                    nxt_done = 1'b1;
                    nxt_state = ST_IDLE;
                end
            end
            default: nxt_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_ff <= ST_IDLE;
            kind_ff <= SLOT_WRITE1;
            cnt_ff <= '0;
            bit_ff <= 1'b1;
            done_ff <= 1'b0;
            oe_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            kind_ff <= nxt_kind;
            cnt_ff <= nxt_cnt;
            bit_ff <= nxt_bit;
            done_ff <= nxt_done;
            oe_ff <= nxt_oe;
        end
    end

    assign line_oe_o = oe_ff;
    assign done_o = done_ff;
    assign bit_o = bit_ff;

endmodule : swpp_slot
